//--- hdl/tier2_pkg.sv
// Purpose: Shared constants for the remote tier-2 message interpreter.
// Assumes: Bytes arrive from a serial receiver already framed into 8-bit words.
// Notes:   Byte codes sit in the top three bits of every control byte.
package tier2_pkg;
    localparam logic [2:0] ADDR_CODE    = 3'h6;
    localparam logic [2:0] DEF_CODE     = 3'h7;
    localparam int         CODE_HI      = 7;
    localparam int         CODE_LO      = 5;
    localparam int         CMD_BIT      = 4;
    localparam int         SINGLE_BIT   = 3;
    localparam int         PAGE_HI      = 4;
    localparam int         PAGE_LO      = 3;
    localparam int         SEL_HI       = 2;
    localparam int         ADDR_HI      = 4;
    localparam logic [1:0] PAGE_ONE     = 2'h0;
    localparam logic [2:0] LOC_HERTZ    = 3'h0;
    localparam logic [2:0] LOC_SQUELCH  = 3'h1;
    localparam logic [7:0] RESERVED_VAL = 8'h00;
    localparam logic [3:0] NIB_ZERO     = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_ACCESS = 3'b001,
        ST_DEF    = 3'b010,
        ST_HDR    = 3'b011,
        ST_DATA   = 3'b100,
        ST_WRITE  = 3'b101
    } state_t;
endpackage

//--- hdl/byte_classify.sv
// Purpose: Classifies one received byte by its top-three-bit code.
// Assumes: Combinational, same clock domain as the caller.
// Notes:   Decoding shared by the interpreter.
`timescale 1ns/1ps
module byte_classify (
    input  logic [7:0] byte_in,   // Byte to classify
    input  logic [4:0] my_addr,   // Configured receiver address
    output logic       is_addr,   // Byte is a receiver address byte
    output logic       addr_hit,  // Address byte matches this receiver
    output logic       is_def     // Byte carries the definition code
);
    assign is_addr  = byte_in[tier2_pkg::CODE_HI:tier2_pkg::CODE_LO]
                      == tier2_pkg::ADDR_CODE;
    assign addr_hit = is_addr && (byte_in[tier2_pkg::ADDR_HI:0] == my_addr);
    assign is_def   = byte_in[tier2_pkg::CODE_HI:tier2_pkg::CODE_LO]
                      == tier2_pkg::DEF_CODE;
endmodule

//--- hdl/tier2_interp.sv
// Purpose: Receiver-side interpreter for second-tier remote messages.
// Assumes: rx_byte/rx_valid come from a serial receiver on clk_sys; tx_ready is
//          a same-clock level from the transmitter.
// Notes:   Tier-2 reads answer from option inputs; commands leave on the cmd ports.
`timescale 1ns/1ps
module tier2_interp (
    input  logic       clk_sys,        // System clock, 50 MHz
    input  logic       rst_b,          // Asynchronous reset, active low
    input  logic [4:0] my_addr,        // Configured receiver address
    input  logic [7:0] rx_byte,        // Received byte
    input  logic       rx_valid,       // One-cycle strobe with rx_byte
    input  logic       hertz_fitted,   // Fine-tuning option fitted
    input  logic [3:0] hertz_digit,    // Units-of-hertz BCD digit
    input  logic       squelch_fitted, // Carrier-operated squelch option fitted
    input  logic [7:0] squelch_in,     // Squelch threshold and flag byte
    input  logic       tx_ready,       // Transmitter can take a byte
    output logic [7:0] tx_byte,        // Byte to transmit
    output logic       tx_valid,       // One-cycle strobe with tx_byte
    output logic [7:0] cmd_byte,       // Commanded tier-2 data byte
    output logic [1:0] cmd_page,       // Page of commanded byte
    output logic [2:0] cmd_loc,        // Location of commanded byte
    output logic       cmd_valid       // One-cycle strobe with commanded byte
);
    tier2_pkg::state_t state_r;
    tier2_pkg::state_t state_nxt;
    logic [1:0] page_r;
    logic [2:0] code_r;
    logic [2:0] loc_r;
    logic       single_r;
    logic [2:0] cnt_r;
    logic       is_addr;
    logic       addr_hit;
    logic       is_def;
    logic       send;
    logic [7:0] rd_val;
    logic [2:0] rd_loc;
    logic [7:0] hertz_val;
    logic [7:0] squelch_val;
    logic       last_loc;
    logic       def_single;
    logic       def_cmd;
    // Named strobes for bytes taken and bytes sent in the current state, then the page and location hits and the header byte.
    logic       acc_take;
    logic       def_take;
    logic       wr_take;
    logic       hdr_go;
    logic       data_go;
    logic       page_one;
    logic       hit_hertz;
    logic       hit_squelch;
    logic [7:0] hdr_byte;

    byte_classify u_cls (
        .byte_in  (rx_byte),
        .my_addr  (my_addr),
        .is_addr  (is_addr),
        .addr_hit (addr_hit),
        .is_def   (is_def)
    );

    assign send       = tx_ready && !tx_valid;
    assign def_single = rx_byte[tier2_pkg::SINGLE_BIT];
    assign def_cmd    = rx_byte[tier2_pkg::CMD_BIT];
    assign rd_loc     = single_r ? loc_r : cnt_r;
    assign last_loc   = single_r || (cnt_r == 3'h7);
    assign hertz_val  = hertz_fitted ? {hertz_digit, tier2_pkg::NIB_ZERO}
                                     : tier2_pkg::RESERVED_VAL;
    assign squelch_val = squelch_fitted ? squelch_in
                                        : tier2_pkg::RESERVED_VAL;
    // Byte-taking strobes feed only the datapath registers; the state logic decodes rx_valid itself.
    assign acc_take    = rx_valid && is_def && (state_r == tier2_pkg::ST_ACCESS);
    assign def_take    = rx_valid && is_def && (state_r == tier2_pkg::ST_DEF);
    assign wr_take     = rx_valid && !is_addr && (state_r == tier2_pkg::ST_WRITE);
    assign hdr_go      = send && (state_r == tier2_pkg::ST_HDR);
    assign data_go     = send && (state_r == tier2_pkg::ST_DATA);
    assign hdr_byte    = {tier2_pkg::ADDR_CODE, my_addr};
    assign page_one    = (page_r == tier2_pkg::PAGE_ONE);
    assign hit_hertz   = page_one && (rd_loc == tier2_pkg::LOC_HERTZ);
    assign hit_squelch = page_one && (rd_loc == tier2_pkg::LOC_SQUELCH);
    assign rd_val = hit_hertz   ? hertz_val   :
                    hit_squelch ? squelch_val :
                    tier2_pkg::RESERVED_VAL;

    // A matching address byte restarts the message from any receive state.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tier2_pkg::ST_IDLE: begin
                if (rx_valid && addr_hit) begin
                    state_nxt = tier2_pkg::ST_ACCESS;
                end
            end
            tier2_pkg::ST_ACCESS: begin
                if (rx_valid) begin
                    if (addr_hit) begin
                        state_nxt = tier2_pkg::ST_ACCESS;
                    end else if (is_def) begin
                        state_nxt = tier2_pkg::ST_DEF;
                    end else begin
                        state_nxt = tier2_pkg::ST_IDLE;
                    end
                end
            end
            tier2_pkg::ST_DEF: begin
                if (rx_valid) begin
                    if (addr_hit) begin
                        state_nxt = tier2_pkg::ST_ACCESS;
                    end else if (!is_def) begin
                        state_nxt = tier2_pkg::ST_IDLE;
                    end else if (def_cmd) begin
                        state_nxt = tier2_pkg::ST_WRITE;
                    end else begin
                        state_nxt = tier2_pkg::ST_HDR;
                    end
                end
            end
            tier2_pkg::ST_HDR: begin
                if (send) begin
                    state_nxt = tier2_pkg::ST_DATA;
                end
            end
            tier2_pkg::ST_DATA: begin
                if (send && last_loc) begin
                    state_nxt = tier2_pkg::ST_IDLE;
                end
            end
            tier2_pkg::ST_WRITE: begin
                if (rx_valid) begin
                    if (is_addr) begin
                        state_nxt = addr_hit ? tier2_pkg::ST_ACCESS
                                             : tier2_pkg::ST_IDLE;
                    end else if (last_loc) begin
                        state_nxt = tier2_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = tier2_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= tier2_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Access-byte fields and definition-byte selection are latched here.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            page_r   <= 2'h0;
            code_r   <= 3'h0;
            loc_r    <= 3'h0;
            single_r <= 1'b0;
        end else if (acc_take) begin
            page_r <= rx_byte[tier2_pkg::PAGE_HI:tier2_pkg::PAGE_LO];
            code_r <= rx_byte[tier2_pkg::SEL_HI:0];
        end else if (def_take) begin
            loc_r    <= rx_byte[tier2_pkg::SEL_HI:0];
            single_r <= def_single;
        end
    end

    // One counter walks the locations for both the answer and the command data.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 3'h0;
        end else if (state_r == tier2_pkg::ST_DEF) begin
            cnt_r <= 3'h0;
        end else if (data_go || wr_take) begin
            cnt_r <= cnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_byte  <= 8'h00;
            tx_valid <= 1'b0;
        end else if (hdr_go) begin
            tx_byte  <= hdr_byte;
            tx_valid <= 1'b1;
        end else if (data_go) begin
            tx_byte  <= rd_val;
            tx_valid <= 1'b1;
        end else begin
            tx_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd_byte  <= 8'h00;
            cmd_page  <= 2'h0;
            cmd_loc   <= 3'h0;
            cmd_valid <= 1'b0;
        end else if (wr_take) begin
            cmd_byte  <= rx_byte;
            cmd_page  <= page_r;
            cmd_loc   <= rd_loc;
            cmd_valid <= 1'b1;
        end else begin
            cmd_valid <= 1'b0;
        end
    end

    // The tier-2 code of the access byte is kept for future expansion.
    logic code_unused;
    assign code_unused = ^code_r;
endmodule

//--- test/tier2_interp_asserts.sv
// Purpose: Port-level assertions for the tier-2 interpreter.
// Assumes: One clock domain with an active-low asynchronous reset.
// Notes:   Bound to every tier2_interp instance.
`timescale 1ns/1ps
module tier2_interp_asserts (
    input logic       clk_sys,   // Clock
    input logic       rst_b,     // Reset
    input logic [7:0] rx_byte,   // Received byte
    input logic       rx_valid,  // Byte strobe
    input logic       tx_ready,  // Sender ready
    input logic [7:0] tx_byte,   // Sent byte
    input logic       tx_valid,  // Sent strobe
    input logic [7:0] cmd_byte,  // Command data
    input logic       cmd_valid  // Command strobe
);
    logic [1:0] seen_r;
    // Counts bytes since the last address byte, saturating at three, since no answer
    // or command may come before the address, access and definition bytes of a message.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            seen_r <= 2'h0;
        end else if (rx_valid && rx_byte[7:5] == 3'h6) begin
            seen_r <= 2'h1;
        end else if (rx_valid && seen_r != 2'h3) begin
            seen_r <= seen_r + 2'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    property p_tx_one; tx_valid |=> !tx_valid; endproperty
    a_tx_one: assert property (p_tx_one) else $error("tx_valid held");
    property p_tx_rdy; tx_valid |-> $past(tx_ready) && !$past(tx_valid); endproperty
    a_tx_rdy: assert property (p_tx_rdy) else $error("send without ready");
    property p_tx_hold; !tx_valid |-> $stable(tx_byte); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx_byte moved");
    property p_cmd_src; cmd_valid |-> $past(rx_valid) && cmd_byte == $past(rx_byte); endproperty
    a_cmd_src: assert property (p_cmd_src) else $error("command data wrong");
    property p_excl; !(tx_valid && cmd_valid); endproperty
    a_excl: assert property (p_excl) else $error("answer during command");
    property p_tx_late; tx_valid |-> seen_r == 2'h3; endproperty
    a_tx_late: assert property (p_tx_late) else $error("answer too early");
    property p_cmd_late; cmd_valid |-> seen_r == 2'h3; endproperty
    a_cmd_late: assert property (p_cmd_late) else $error("command too early");
    property p_rst_quiet; $rose(rst_b) |-> !tx_valid && !cmd_valid; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("output after reset");
    c_tx: cover property (tx_valid ##2 tx_valid);
    c_cmd: cover property (cmd_valid);
    c_rst: cover property ($rose(rst_b));
endmodule
bind tier2_interp tier2_interp_asserts i_tier2_interp_asserts (.clk_sys(clk_sys),
    .rst_b(rst_b), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid));

//--- test/remote_ctl_model.sv
// Purpose: Remote controller model on the serial side of the interpreter.
// Assumes: Bytes arrive already framed; one byte every two cycles.
// Notes:   Slow mode stalls the transmitter every other cycle.
`timescale 1ns/1ps
module remote_ctl_model (
    input  logic       clk_sys,  // Clock
    input  logic       slow,     // Stall request
    output logic [7:0] rx_byte,  // Byte to receiver
    output logic       rx_valid, // Byte strobe
    output logic       tx_ready  // Transmitter ready
);
    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b1;
    end
    always @(negedge clk_sys) tx_ready <= slow ? !tx_ready : 1'b1;
    task automatic send(input logic [7:0] b);
        @(negedge clk_sys);
        rx_byte = b;
        rx_valid = 1'b1;
        @(negedge clk_sys);
        rx_valid = 1'b0;
        // A released line shows the inverse so stale data is never mistaken for valid.
        rx_byte = ~b;
    endtask
endmodule

//--- test/remote_tier2_message_protocol_tb.sv
// Purpose: Random message bench for the tier-2 interpreter.
// Assumes: The controller model supplies bytes and transmitter ready.
// Notes:   Expected answers come from a queue model in the bench.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", nm, ex, got); end end
module remote_tier2_message_protocol_tb;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [4:0]  my_addr = 5'h00;
    logic        hertz_fitted = 1'b0, squelch_fitted = 1'b0, slow = 1'b0;
    logic [3:0]  hertz_digit = 4'h0;
    logic [7:0]  squelch_in = 8'h00, rx_byte, tx_byte, cmd_byte, e8;
    logic        rx_valid, tx_ready, tx_valid, cmd_valid;
    logic [1:0]  cmd_page;
    logic [2:0]  cmd_loc;
    logic [12:0] e13;
    logic [15:0] lf = 16'h049D;
    logic [7:0]  exp_tx[$];
    logic [12:0] exp_cmd[$];
    int          n_mismatch = 0, check_count = 0, cyc = 0;
    always #10 clk_sys = ~clk_sys;
    tier2_interp i_tier2_interp (.clk_sys(clk_sys), .rst_b(rst_b), .my_addr(my_addr),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .hertz_fitted(hertz_fitted),
        .hertz_digit(hertz_digit), .squelch_fitted(squelch_fitted), .squelch_in(squelch_in),
        .tx_ready(tx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid), .cmd_byte(cmd_byte),
        .cmd_page(cmd_page), .cmd_loc(cmd_loc), .cmd_valid(cmd_valid));
    remote_ctl_model i_remote_ctl_model (.clk_sys(clk_sys), .slow(slow),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_ready(tx_ready));
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] loc_val(input logic [1:0] pg, input logic [2:0] lc);
        if (pg != 2'h0 || lc > 3'h1) return 8'h00;
        if (lc == 3'h0) return hertz_fitted ? {hertz_digit, 4'h0} : 8'h00;
        return squelch_fitted ? squelch_in : 8'h00;
    endfunction
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(negedge clk_sys) begin
        cyc++;
        if (cyc > 40000) begin
            n_mismatch++;
            finish_test();
        end else begin
            if (tx_valid === 1'b1) begin
                e8 = (exp_tx.size() != 0) ? exp_tx.pop_front() : 8'hXX;
                `CHK("tx_byte", e8, tx_byte)
            end
            if (cmd_valid === 1'b1) begin
                e13 = (exp_cmd.size() != 0) ? exp_cmd.pop_front() : 13'h1XXX;
                `CHK("cmd", e13, {cmd_page, cmd_loc, cmd_byte})
            end
        end
    end
    initial begin
        logic [15:0] a, b;
        logic [7:0]  d;
        logic        ok;
        repeat (6) @(negedge clk_sys);
        rst_b = 1'b1;
        for (int n = 0; n < 60; n++) begin
            a = step(lf);
            b = step(a);
            lf = b;
            @(negedge clk_sys);
            my_addr = a[12:8];
            hertz_fitted = a[0];
            squelch_fitted = a[1];
            hertz_digit = a[5:2] % 4'hA;
            squelch_in = b[15:8];
            slow = b[12];
            ok = b[9:7] != 3'h0 && b[11:10] != 2'h0;
            if (ok && !b[0]) exp_tx.push_back({3'h6, my_addr});
            if (b[13]) i_remote_ctl_model.send({3'h6, my_addr});
            i_remote_ctl_model.send({3'h6, b[9:7] != 3'h0 ? my_addr : ~my_addr});
            i_remote_ctl_model.send({b[11:10] == 2'h0 ? 3'h5 : 3'h7, b[6:5], b[2:0]});
            i_remote_ctl_model.send({3'h7, b[0], b[1], 2'h0, b[4]});
            for (int k = 0; k < 8; k++) begin
                if (b[1] && 3'(k) != {2'h0, b[4]}) continue;
                lf = step(lf);
                d = {lf[7], 1'b0, lf[5:0]};
                if (ok && b[0]) exp_cmd.push_back({b[6:5], 3'(k), d});
                if (ok && !b[0]) exp_tx.push_back(loc_val(b[6:5], 3'(k)));
                if (b[0]) i_remote_ctl_model.send(d);
            end
            for (int w = 0; w < 200 && exp_tx.size() + exp_cmd.size() != 0; w++)
                @(negedge clk_sys);
            repeat (6) @(negedge clk_sys);
            `CHK("pending", 0, exp_tx.size() + exp_cmd.size())
            $display("test %0d done", n);
        end
        finish_test();
    end
endmodule
